// ---- logic/pfc_manual_fet_command.sv ----
// Protection Manual_fet_command: decides charge and discharge driver state from faults,
// autonomous mode, host commands, body-diode protection and sleep; PWM mode bits are held apart and do not gate the drivers.
// Assumes register writes, reads and subcommands arrive decoded, synchronous to clk;
// temperature/diagnostic conditions and current levels arrive on pins.
`timescale 1ns/1ps
module pfc_manual_fet_command
  import pfc_pkg::*;
#(
  parameter int NPROT = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             regWrite,
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  output logic      [7:0]       regRdata,
  input  wire logic             subcmdValid,
  input  wire logic [15:0]      subcmdCode,
  input  wire logic             cfgAutoModeInit,
  input  wire logic             cfgAutoModeLoad,
  input  wire logic             hostForceOffPermit,
  input  wire logic             hostForceOnPermit,
  input  wire logic             bodyDiodeProtectEn,
  input  wire logic             seriesFetConfig,
  input  wire logic             pwmEnable,
  input  wire logic             sleepChargeDriverOff,
  input  wire logic [NPROT-1:0] protEnable,
  input  wire logic [NPROT-1:0] chargeFetMask,
  input  wire logic [NPROT-1:0] dischargeFetMask,
  input  wire logic [NPROT-1:0] bothFetMask,
  input  wire logic [7:0]       protDelay,
  input  wire logic [NPROT-1:0] protConditionPin,
  input  wire logic             chargingCurrentPin,
  input  wire logic             dischargingCurrentPin,
  input  wire logic             belowSleepThresholdPin,
  output logic                  chargeDriver,
  output logic                  dischargeDriver,
  output logic                  chargePwmMode,
  output logic                  dischargePwmMode,
  output logic                  sleepMode,
  output logic      [7:0]       alertStatus
);

  typedef struct packed {
    logic [NPROT-1:0] condMeta;
    logic [NPROT-1:0] condSync;
    logic [2:0]       curMeta;
    logic [2:0]       curSync;
    logic             autoMode;
    logic [3:0]       manualCmd;
    logic             chgPwm;
    logic             dsgPwm;
    pfc_power_type    power;
    logic             chgDrv;
    logic             dsgDrv;
    logic [7:0]       rdata;
    logic [7:0]       alerts;
  } pfc_state_type;

  pfc_state_type st_reg;
  pfc_state_type st_next;

  logic [NPROT-1:0] faultVec;
  logic [NPROT-1:0] alertVec;

  // One channel per protection, fed from the synchronised pins
  for (genvar i = 0; i < NPROT; i++) begin : g_chan
    pfc_prot_if pi ();
    assign pi.overThreshold = st_reg.condSync[i];
    assign pi.protEnable    = protEnable[i];
    assign pi.delayCount    = protDelay;
    assign faultVec[i]      = pi.fault;
    assign alertVec[i]      = pi.alert;
    pfc_prot_channel u_chan (
      .clk (clk),
      .rst (rst),
      .p   (pi.chan)
    );
  end

  logic chgFaultOff;
  logic dsgFaultOff;
  logic chgForceOff;
  logic dsgForceOff;
  logic chgForceOn;
  logic dsgForceOn;
  logic charging;
  logic discharging;
  logic belowSleep;
  logic chgWant;
  logic dsgWant;
  logic [7:0] faultByte;

  always_comb begin
    charging    = st_reg.curSync[0];
    discharging = st_reg.curSync[1];
    belowSleep  = st_reg.curSync[2];
    // Mapped faults only; a fault not steered to a FET just reports
    chgFaultOff = |(faultVec & (chargeFetMask | bothFetMask));
    dsgFaultOff = |(faultVec & (dischargeFetMask | bothFetMask));
    chgForceOff = hostForceOffPermit & st_reg.manualCmd[CMD_CHARGE_FORCE_OFF_BIT];
    dsgForceOff = hostForceOffPermit & st_reg.manualCmd[CMD_DISCHARGE_FORCE_OFF_BIT];
    chgForceOn  = hostForceOnPermit & st_reg.manualCmd[CMD_CHARGE_FORCE_ON_BIT];
    dsgForceOn  = hostForceOnPermit & st_reg.manualCmd[CMD_DISCHARGE_FORCE_ON_BIT];
    faultByte   = '0;
    faultByte[NPROT-1:0] = faultVec;
  end

  always_comb begin
    st_next = st_reg;
    st_next.condMeta = protConditionPin;
    st_next.condSync = st_reg.condMeta;
    st_next.curMeta  = {belowSleepThresholdPin, dischargingCurrentPin, chargingCurrentPin};
    st_next.curSync  = st_reg.curMeta;
    st_next.alerts   = '0;
    st_next.alerts[NPROT-1:0] = alertVec;

    if (cfgAutoModeLoad) begin
      st_next.autoMode = cfgAutoModeInit;
    end else if (subcmdValid && subcmdCode == FET_ENABLE_SUBCMD) begin
      st_next.autoMode = !st_reg.autoMode;
    end

    // Written regardless of the autonomous bit; bits 7-4 reserved
    if (regWrite && regAddr == MANUAL_FET_COMMAND_OFS) begin
      st_next.manualCmd = regWdata[3:0];
    end
    if (regWrite && pwmEnable && regAddr == DSG_PWM_CONTROL_OFS) begin
      st_next.dsgPwm = regWdata[0];
    end
    if (regWrite && pwmEnable && regAddr == CHG_PWM_CONTROL_OFS) begin
      st_next.chgPwm = regWdata[0];
    end

    // Sleep only while current is small, any real current wakes
    unique case (st_reg.power)
      PFC_NORMAL: if (belowSleep && !charging && !discharging) st_next.power = PFC_SLEEP;
      PFC_SLEEP:  if (charging || discharging) st_next.power = PFC_NORMAL;
    endcase

    // Autonomous on, else manual force-on only
    chgWant = (st_reg.autoMode && !chgFaultOff) || chgForceOn;
    dsgWant = (st_reg.autoMode && !dsgFaultOff) || dsgForceOn;
    if (st_reg.power == PFC_SLEEP && sleepChargeDriverOff) begin
      chgWant = 1'b0;
    end
    // Force-off wins over force-on and autonomy alike
    if (chgForceOff) chgWant = 1'b0;
    if (dsgForceOff) dsgWant = 1'b0;
    // Body diode: enable the off FET when current flows through its diode
    if (bodyDiodeProtectEn && seriesFetConfig && (chgWant ^ dsgWant)) begin
      if (!dsgWant && charging) dsgWant = 1'b1;
      if (!chgWant && discharging) chgWant = 1'b1;
    end
    st_next.chgDrv = chgWant;
    st_next.dsgDrv = dsgWant;

    unique case (regAddr)
      FAULT_STATUS_TEMP_DIAG_OFS: st_next.rdata = faultByte;
      MANUAL_FET_COMMAND_OFS:     st_next.rdata = {4'h0, st_reg.manualCmd};
      BATTERY_STATUS_OFS: begin
        st_next.rdata = 8'h00;
        st_next.rdata[BS_CHG_BIT] = st_reg.chgDrv;
        st_next.rdata[BS_DSG_BIT] = st_reg.dsgDrv;
      end
      default:                    st_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.autoMode  <= AUTO_MODE_RESET;
      st_reg.manualCmd <= MANUAL_CMD_RESET;
      st_reg.power     <= PFC_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // PWM on both drivers is the host's burden and is not blocked here
  assign chargeDriver     = st_reg.chgDrv;
  assign dischargeDriver  = st_reg.dsgDrv;
  assign chargePwmMode    = st_reg.chgPwm;
  assign dischargePwmMode = st_reg.dsgPwm;
  assign sleepMode        = (st_reg.power == PFC_SLEEP);
  assign regRdata         = st_reg.rdata;
  assign alertStatus      = st_reg.alerts;

  a_autooff_manual_off: assert property (@(posedge clk) disable iff (rst)
    !st_reg.autoMode && !(hostForceOnPermit && st_reg.manualCmd[CMD_CHARGE_FORCE_ON_BIT]) && !bodyDiodeProtectEn
    |=> !chargeDriver) else $error("charge on without auto or manual");
  a_force_off_chg: assert property (@(posedge clk) disable iff (rst)
    hostForceOffPermit && st_reg.manualCmd[CMD_CHARGE_FORCE_OFF_BIT] && !bodyDiodeProtectEn |=> !chargeDriver)
    else $error("charge force-off ignored");
  a_force_off_dsg: assert property (@(posedge clk) disable iff (rst)
    hostForceOffPermit && st_reg.manualCmd[CMD_DISCHARGE_FORCE_OFF_BIT] && !bodyDiodeProtectEn |=> !dischargeDriver)
    else $error("discharge force-off ignored");
  a_force_on_chg: assert property (@(posedge clk) disable iff (rst)
    hostForceOnPermit && st_reg.manualCmd[CMD_CHARGE_FORCE_ON_BIT] && !chgForceOff
    && !(st_reg.power == PFC_SLEEP && sleepChargeDriverOff) |=> chargeDriver)
    else $error("charge force-on ignored");
  a_force_on_dsg: assert property (@(posedge clk) disable iff (rst)
    hostForceOnPermit && st_reg.manualCmd[CMD_DISCHARGE_FORCE_ON_BIT] && !dsgForceOff |=> dischargeDriver)
    else $error("discharge force-on ignored");
  a_fault_off_dsg: assert property (@(posedge clk) disable iff (rst)
    dsgFaultOff && !dsgForceOn && !bodyDiodeProtectEn |=> !dischargeDriver)
    else $error("mapped fault left discharge on");
  a_toggle_auto: assert property (@(posedge clk) disable iff (rst)
    subcmdValid && subcmdCode == FET_ENABLE_SUBCMD && !cfgAutoModeLoad |=> st_reg.autoMode != $past(st_reg.autoMode))
    else $error("auto bit not toggled");
  a_pwm_gated: assert property (@(posedge clk) disable iff (rst)
    !pwmEnable |=> $stable(chargePwmMode) && $stable(dischargePwmMode))
    else $error("PWM changed without enable");
  a_status_drivers: assert property (@(posedge clk) disable iff (rst)
    regAddr == BATTERY_STATUS_OFS |=> regRdata[BS_CHG_BIT] == $past(chargeDriver))
    else $error("battery status mismatches driver");
  a_status_dsg_bit: assert property (@(posedge clk) disable iff (rst)
    regAddr == BATTERY_STATUS_OFS |=> regRdata[BS_DSG_BIT] == $past(dischargeDriver))
    else $error("battery status mismatches discharge driver");
  a_cmd_holds: assert property (@(posedge clk) disable iff (rst)
    !(regWrite && regAddr == MANUAL_FET_COMMAND_OFS) |=> $stable(st_reg.manualCmd))
    else $error("manual bits changed without write");
  a_sleep_charge_force_off: assert property (@(posedge clk) disable iff (rst)
    sleepMode && sleepChargeDriverOff && !bodyDiodeProtectEn |=> !chargeDriver)
    else $error("charge on in sleep");
  a_wake_on_current: assert property (@(posedge clk) disable iff (rst)
    sleepMode && (charging || discharging) |=> !sleepMode)
    else $error("no wake on current");

endmodule

// ---- logic/pfc_pkg.sv ----
// Package for the protection Manual_fet_command block: command codes, register offsets,
// field positions, reset values and state encodings.
// Assumes a command decoder outside that presents byte writes and reads by code.
package pfc_pkg;

  localparam logic [7:0]  FAULT_STATUS_TEMP_DIAG_OFS = 8'h05;
  localparam logic [7:0]  MANUAL_FET_COMMAND_OFS     = 8'h29;
  localparam logic [7:0]  BATTERY_STATUS_OFS         = 8'h12;
  localparam logic [7:0]  DSG_PWM_CONTROL_OFS        = 8'h6A;
  localparam logic [7:0]  CHG_PWM_CONTROL_OFS        = 8'h6C;
  localparam logic [15:0] FET_ENABLE_SUBCMD          = 16'h0022;

  // Manual FET command field positions
  localparam int CMD_CHARGE_FORCE_OFF_BIT = 3;
  localparam int CMD_DISCHARGE_FORCE_OFF_BIT = 2;
  localparam int CMD_CHARGE_FORCE_ON_BIT  = 1;
  localparam int CMD_DISCHARGE_FORCE_ON_BIT  = 0;
  localparam logic [3:0] MANUAL_CMD_RESET = 4'h0;

  // Fault status byte positions, top to bottom
  localparam int FS_OTD_BIT   = 7;
  localparam int FS_OTC_BIT   = 6;
  localparam int FS_UTD_BIT   = 5;
  localparam int FS_UTC_BIT   = 4;
  localparam int FS_INTERNAL_OVERTEMP_FAULT_BIT = 3;
  localparam int FS_HWD_BIT   = 2;
  localparam int FS_VREF_BIT  = 1;
  localparam int FS_VSS_BIT   = 0;

  // Battery status word driver bits (low byte)
  localparam int BS_CHG_BIT = 3;
  localparam int BS_DSG_BIT = 2;

  localparam logic AUTO_MODE_RESET = 1'b0;

  typedef enum logic [0:0] {PFC_NORMAL, PFC_SLEEP} pfc_power_type;

endpackage

// ---- logic/pfc_prot_channel.sv ----
// One protection channel: alert on first crossing when the delay exceeds 1, fault after the programmed delay.
// Assumes overThreshold is already synchronous to clk; recovery is the condition clearing.
`timescale 1ns/1ps
module pfc_prot_channel
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pfc_prot_if.chan p
);
  typedef struct packed {
    logic       alert;
    logic       fault;
    logic [7:0] count;
  } pfc_chan_type;

  pfc_chan_type st_reg;
  pfc_chan_type st_next;

  always_comb begin
    st_next = st_reg;
    if (!p.protEnable || !p.overThreshold) begin
      st_next.alert = 1'b0;
      st_next.fault = 1'b0;
      st_next.count = 8'h00;
    end else if (!st_reg.fault) begin
      // Alert on first crossing when the delay exceeds 1, fault once the delay has run out
      if (st_reg.count + 8'h01 >= p.delayCount) begin
        st_next.fault = 1'b1;
        st_next.alert = 1'b0;
      end else begin
        st_next.alert = 1'b1;
        st_next.count = st_reg.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign p.alert = st_reg.alert;
  assign p.fault = st_reg.fault;

  a_fault_clears_alert: assert property (@(posedge clk) disable iff (rst)
    st_reg.fault |-> !st_reg.alert) else $error("alert stands with fault");
  a_alert_precedes_fault: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.fault) && p.delayCount > 8'h01 |-> $past(st_reg.alert))
    else $error("fault without prior alert");

endmodule

// ---- logic/pfc_prot_if.sv ----
// Interface carrying one protection channel's condition and its alert/fault results.
// Assumes the channel's delay count is held steady by the owner.
`timescale 1ns/1ps
interface pfc_prot_if;
  logic overThreshold;
  logic protEnable;
  logic [7:0] delayCount;
  logic alert;
  logic fault;
  modport chan (input overThreshold, input protEnable, input delayCount, output alert, output fault);
  modport owner (output overThreshold, output protEnable, output delayCount, input alert, input fault);
endinterface

// ---- verif/pfc_host_model.sv ----
// Host model: issues register writes, reads and subcommands to the Manual_fet_command block.
// Assumes the bench clock; outputs change only at the falling edge.
`timescale 1ns/1ps
module pfc_host_model
  import pfc_pkg::*;
(
  input  wire logic        clk,
  output logic             regWrite,
  output logic [7:0]       regAddr,
  output logic [7:0]       regWdata,
  input  wire logic [7:0]  regRdata,
  output logic             subcmdValid,
  output logic [15:0]      subcmdCode
);
  initial begin
    {regWrite, subcmdValid, regAddr, regWdata, subcmdCode} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    // Released data is scrambled so a stale byte is never mistaken for a write
    regWdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    repeat (2) @(negedge clk);
    d = regRdata;
  endtask

  task automatic sub(input logic [15:0] c);
    @(negedge clk);
    subcmdCode = c;
    subcmdValid = 1'b1;
    @(negedge clk);
    subcmdValid = 1'b0;
    subcmdCode = ~c;
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the protection Manual_fet_command block.
// Assumes a 40 MHz clock and the host model as the only register master.
`timescale 1ns/1ps
module tb;
  import pfc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        regWrite, subcmdValid, cfgAutoModeInit, cfgAutoModeLoad, hostForceOffPermit, hostForceOnPermit;
  logic        bodyDiodeProtectEn, seriesFetConfig, pwmEnable, sleepChargeDriverOff;
  logic        chargingCurrentPin, dischargingCurrentPin, belowSleepThresholdPin;
  logic        chargeDriver, dischargeDriver, chargePwmMode, dischargePwmMode, sleepMode;
  logic [7:0]  regAddr, regWdata, regRdata, protEnable, chargeFetMask, dischargeFetMask, bothFetMask;
  logic [7:0]  protDelay, protConditionPin, alertStatus, rd;
  logic [15:0] subcmdCode;
  int          fail_count = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  pfc_host_model host (.clk, .regWrite, .regAddr, .regWdata, .regRdata, .subcmdValid, .subcmdCode);

  pfc_manual_fet_command #(.NPROT(8)) dut (
    .clk, .rst, .regWrite, .regAddr, .regWdata, .regRdata, .subcmdValid, .subcmdCode, .cfgAutoModeInit,
    .cfgAutoModeLoad, .hostForceOffPermit, .hostForceOnPermit, .bodyDiodeProtectEn, .seriesFetConfig,
    .pwmEnable, .sleepChargeDriverOff, .protEnable, .chargeFetMask, .dischargeFetMask, .bothFetMask,
    .protDelay, .protConditionPin, .chargingCurrentPin, .dischargingCurrentPin, .belowSleepThresholdPin,
    .chargeDriver, .dischargeDriver, .chargePwmMode, .dischargePwmMode, .sleepMode, .alertStatus
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Drivers as {charge, discharge} after n falling edges
  task automatic drv(input int n, input logic [1:0] exp);
    repeat (n) @(negedge clk);
    chk("drivers", {6'h00, exp}, {6'h00, chargeDriver, dischargeDriver});
  endtask

  task automatic pwm(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
    host.wr(a, d);
    repeat (3) @(negedge clk);
    chk("pwm modes", {6'h00, exp}, {6'h00, chargePwmMode, dischargePwmMode});
  endtask

  task automatic t_reset;
    drv(1, 2'b00);
    host.rd(MANUAL_FET_COMMAND_OFS, rd);
    chk("manual cmd", 8'h00, rd);
    host.rd(FAULT_STATUS_TEMP_DIAG_OFS, rd);
    chk("fault byte", 8'h00, rd);
    $display("reset test done");
  endtask

  task automatic t_manual;
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h01);
    drv(3, 2'b00);
    hostForceOnPermit = 1'b1;
    drv(3, 2'b01);
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h02);
    drv(3, 2'b10);
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h03);
    drv(3, 2'b11);
    host.rd(BATTERY_STATUS_OFS, rd);
    chk("status drivers", 8'h0C, rd & 8'h0C);
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h00);
    drv(3, 2'b00);
    $display("manual test done");
  endtask

  task automatic t_auto;
    host.sub(16'h0021);
    drv(3, 2'b00);
    host.sub(FET_ENABLE_SUBCMD);
    drv(3, 2'b11);
    host.sub(FET_ENABLE_SUBCMD);
    drv(3, 2'b00);
    cfgAutoModeInit = 1'b1;
    cfgAutoModeLoad = 1'b1;
    @(negedge clk);
    cfgAutoModeLoad = 1'b0;
    drv(3, 2'b11);
    $display("autonomous test done");
  endtask

  task automatic t_force_off;
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h08);
    drv(3, 2'b11);
    hostForceOffPermit = 1'b1;
    drv(3, 2'b01);
    // Discharge forced both off and on: off must win
    host.wr(MANUAL_FET_COMMAND_OFS, 8'hF7);
    drv(3, 2'b10);
    host.rd(MANUAL_FET_COMMAND_OFS, rd);
    chk("manual cmd", 8'h07, rd);
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h00);
    drv(3, 2'b11);
    $display("force-off test done");
  endtask

  task automatic t_faults;
    int k;
    protEnable = 8'hFF;
    protDelay = 8'h04;
    for (int i = 0; i < 8; i++) begin
      chargeFetMask = (i % 3 == 0) ? 8'(1 << i) : 8'h00;
      dischargeFetMask = (i % 3 == 1) ? 8'(1 << i) : 8'h00;
      bothFetMask = (i % 3 == 2) ? 8'(1 << i) : 8'h00;
      protConditionPin[i] = 1'b1;
      for (k = 0; k < 8 && alertStatus[i] !== 1'b1; k++) @(negedge clk);
      chk("alert", 8'(1 << i), alertStatus);
      drv(10, (i % 3 == 0) ? 2'b01 : (i % 3 == 1) ? 2'b10 : 2'b00);
      chk("alert", 8'h00, alertStatus);
      host.rd(FAULT_STATUS_TEMP_DIAG_OFS, rd);
      chk("fault byte", 8'(1 << i), rd);
      protConditionPin[i] = 1'b0;
      drv(6, 2'b11);
    end
    $display("fault test done");
  endtask

  task automatic t_body_diode;
    seriesFetConfig = 1'b1;
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h04);
    chargingCurrentPin = 1'b1;
    drv(6, 2'b10);
    bodyDiodeProtectEn = 1'b1;
    drv(4, 2'b11);
    chargingCurrentPin = 1'b0;
    drv(6, 2'b10);
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h08);
    dischargingCurrentPin = 1'b1;
    drv(6, 2'b11);
    dischargingCurrentPin = 1'b0;
    seriesFetConfig = 1'b0;
    host.wr(MANUAL_FET_COMMAND_OFS, 8'h00);
    drv(6, 2'b11);
    $display("body diode test done");
  endtask

  task automatic t_sleep;
    // Body diode off so the sleep rule alone decides the charge driver
    bodyDiodeProtectEn = 1'b0;
    sleepChargeDriverOff = 1'b1;
    belowSleepThresholdPin = 1'b1;
    drv(6, 2'b01);
    chk("sleep", 8'h01, {7'h00, sleepMode});
    dischargingCurrentPin = 1'b1;
    drv(6, 2'b11);
    chk("sleep", 8'h00, {7'h00, sleepMode});
    dischargingCurrentPin = 1'b0;
    $display("sleep test done");
  endtask

  // Only one driver is placed in PWM at a time
  task automatic t_pwm;
    pwm(DSG_PWM_CONTROL_OFS, 8'h01, 2'b00);
    pwmEnable = 1'b1;
    pwm(DSG_PWM_CONTROL_OFS, 8'h01, 2'b01);
    pwm(DSG_PWM_CONTROL_OFS, 8'h00, 2'b00);
    pwm(CHG_PWM_CONTROL_OFS, 8'h01, 2'b10);
    pwm(CHG_PWM_CONTROL_OFS, 8'h00, 2'b00);
    $display("pwm test done");
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {cfgAutoModeInit, cfgAutoModeLoad, hostForceOffPermit, hostForceOnPermit, bodyDiodeProtectEn} = '0;
    {seriesFetConfig, pwmEnable, sleepChargeDriverOff, chargingCurrentPin, dischargingCurrentPin} = '0;
    {belowSleepThresholdPin, protEnable, chargeFetMask, dischargeFetMask, bothFetMask, protConditionPin} = '0;
    protDelay = 8'h04;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_manual;
    t_auto;
    t_force_off;
    t_faults;
    t_body_diode;
    t_sleep;
    t_pwm;
    conclude;
  end
endmodule
